// ==== logic/sar_adc_lvds_readout.sv ====
// Decided for this implementation: the placing of the registers and the APB slave port.
`default_nettype none
`include "sar_adc_regs.svh"

module sar_adc_lvds_readout
  import sar_adc_pkg::*;
#(
  parameter int          RES_W   = `SAR_RES_W,
  parameter logic [17:0] PAT_RST = `SAR_PAT_RST
) (
  input  wire logic             pclk,               // APB and sampling clock, 50 MHz
  input  wire logic             presetn,            // Async reset, active low
  input  wire logic             psel,               // APB select
  input  wire logic             penable,            // APB enable
  input  wire logic             pwrite,             // APB direction
  input  wire logic [11:0]      paddr,              // APB byte address
  input  wire logic [31:0]      pwdata,             // APB write data
  output logic      [31:0]      prdata,             // APB read data
  output logic                  pready,             // APB ready
  output logic                  pslverr,            // APB error, unmapped address
  input  wire logic             convert_strobe,     // Conversion start pin
  input  wire logic             readout_clock,      // External readout clock pin
  input  wire logic             sleep_request_n,    // Power-down request, active low
  input  wire logic             pattern_force,      // Test pattern select pin
  input  wire logic             dual_lane_select,   // Two-lane mode select pin
  input  wire logic [RES_W-1:0] analog_sample,      // Digitised stand-in of the input
  output logic                  first_lane_out,     // First data lane
  output logic                  first_lane_oe,      // First lane driver enable
  output logic                  second_lane_out,    // Second data lane
  output logic                  second_lane_oe,     // Second lane driver enable
  output logic                  echoed_clock_out,   // Echoed readout clock
  output logic                  echoed_clock_oe     // Echo driver enable
);
  localparam int CONV_WAIT = `SAR_CONV_WAIT;
  localparam logic [RES_W-1:0] MSB = {1'b1, {(RES_W-1){1'b0}}};

  // Pin synchronisation
  logic [4:0]       pins_s;
  logic [RES_W-1:0] ana_s;
  wire  logic       cnv_s  = pins_s[0];
  wire  logic       clk_s  = pins_s[1];
  wire  logic       slp_s  = pins_s[2];
  wire  logic       pat_s  = pins_s[3];
  wire  logic       dual_s = pins_s[4];

  sar_sync #(.W(5)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({dual_lane_select, pattern_force, sleep_request_n,
               readout_clock, convert_strobe}),
    .q       (pins_s)
  );

  sar_sync #(.W(RES_W)) u_ana_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (analog_sample),
    .q       (ana_s)
  );

  // State
  sar_state_t       state_r;
  sar_state_t       state_nxt;
  logic             cnv_d_r;
  logic             clk_d_r;
  logic [1:0]       wait_r;
  logic [RES_W-1:0] held_r;
  logic [RES_W-1:0] sh_r;
  logic [4:0]       left_r;
  logic             dual_mode_r;
  logic [RES_W-1:0] pat_reg_r;
  logic [RES_W-1:0] last_r;
  logic [31:0]      count_r;

  wire logic cnv_rise = cnv_s & ~cnv_d_r;
  wire logic clk_rise = clk_s & ~clk_d_r;
  wire logic clk_fall = ~clk_s & clk_d_r;
  wire logic conv_done = (state_r == SAR_CONV) && (wait_r == 2'(CONV_WAIT - 1));
  wire logic shifting  = clk_fall && (left_r != 5'h00);
  wire logic [RES_W-1:0] sh_two = {sh_r[RES_W-3:0], 2'b00};
  wire logic [RES_W-1:0] sh_one = {sh_r[RES_W-2:0], 1'b0};

  // Binary search against half, quarter ... one LSB of full scale, in offset binary
  wire logic [RES_W-1:0] target = held_r ^ MSB;
  logic [RES_W-1:0] acc [0:RES_W];
  assign acc[0] = '0;
  genvar gi;
  generate
    for (gi = 0; gi < RES_W; gi++)
    begin : g_sar
      wire logic [RES_W-1:0] trial = acc[gi] | (MSB >> gi);
      assign acc[gi+1] = (trial <= target) ? trial : acc[gi];
    end
  endgenerate
  // Back to two's complement by flipping the MSB
  wire logic [RES_W-1:0] result = acc[RES_W] ^ MSB;
  wire logic [RES_W-1:0] load_word = pat_s ? pat_reg_r : result;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SAR_SLEEP : state_nxt = SAR_ACQ;
      SAR_ACQ   : if (cnv_rise) state_nxt = SAR_CONV;
      SAR_CONV  : if (conv_done) state_nxt = SAR_ACQ;
      default   : state_nxt = SAR_SLEEP;
    endcase
    if (!slp_s)
      state_nxt = SAR_SLEEP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SAR_SLEEP;
      cnv_d_r <= 1'b0;
      clk_d_r <= 1'b0;
      wait_r  <= 2'h0;
      held_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnv_d_r <= cnv_s;
      clk_d_r <= clk_s;
      wait_r  <= (state_r == SAR_CONV) ? wait_r + 2'h1 : 2'h0;
      if (state_r == SAR_ACQ && cnv_rise && slp_s)
        held_r <= ana_s;
    end
  end

  // Readout shift register; the word is loaded the moment conversion ends, so
  // the readout belongs to the conversion just finished
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_r        <= '0;
      left_r      <= 5'h00;
      dual_mode_r <= 1'b0;
      last_r      <= '0;
      count_r     <= 32'h0;
    end
    else if (!slp_s)
    begin
      left_r <= 5'h00;
    end
    else if (conv_done)
    begin
      sh_r        <= load_word;
      left_r      <= dual_s ? `SAR_BITS_TWO : `SAR_BITS_ONE;
      dual_mode_r <= dual_s;
      last_r      <= result;
      count_r     <= count_r + 32'h1;
    end
    else if (shifting)
    begin
      // Data moves on falling edges so it is steady at the echoed rising edge
      sh_r   <= dual_mode_r ? sh_two : sh_one;
      left_r <= left_r - 5'h01;
    end
  end

  // Pin outputs, all from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_lane_out   <= 1'b0;
      second_lane_out  <= 1'b0;
      echoed_clock_out <= 1'b0;
      first_lane_oe    <= 1'b0;
      second_lane_oe   <= 1'b0;
      echoed_clock_oe  <= 1'b0;
    end
    else
    begin
      first_lane_out   <= slp_s & sh_r[RES_W-1];
      second_lane_out  <= slp_s & dual_mode_r & sh_r[RES_W-2];
      echoed_clock_out <= slp_s & clk_s;
      first_lane_oe    <= slp_s;
      second_lane_oe   <= slp_s & dual_s;
      echoed_clock_oe  <= slp_s;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable;
  wire logic hit_ctrl = (paddr == `SAR_OFS_CTRL);
  wire logic hit_stat = (paddr == `SAR_OFS_STATUS);
  wire logic hit_res  = (paddr == `SAR_OFS_RESULT);
  wire logic hit_cnt  = (paddr == `SAR_OFS_COUNT);
  wire logic mapped   = hit_ctrl | hit_stat | hit_res | hit_cnt;
  wire logic [31:0] status_w = {26'h0, (left_r != 5'h00), pat_s, dual_s, slp_s, state_r};
  wire logic [31:0] rd_mux   = hit_ctrl ? {14'h0, pat_reg_r} :
                               hit_stat ? status_w :
                               hit_res  ? {14'h0, last_r} :
                               hit_cnt  ? count_r : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      pat_reg_r <= PAT_RST;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~mapped;
      end
      if (access && pwrite && hit_ctrl)
        pat_reg_r <= pwdata[RES_W-1:0];
    end
  end

  // Checks

  hold_on_edge_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == SAR_ACQ && cnv_rise && slp_s) |=>
      (state_r == SAR_CONV && held_r == $past(ana_s)))
    else $error("strobe edge did not hold the input");

  sleep_quiet_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !slp_s |=> (!first_lane_oe && !second_lane_oe && !echoed_clock_oe && state_r == SAR_SLEEP))
    else $error("drivers active while asleep");

  pattern_load_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (conv_done && slp_s && pat_s) |=> (sh_r == $past(pat_reg_r)))
    else $error("test pattern not loaded");

  dual_shift_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (shifting && slp_s && !conv_done && dual_mode_r) |=>
      (sh_r[RES_W-1:2] == $past(sh_r[RES_W-3:0])))
    else $error("two-lane shift wrong");

  single_shift_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (shifting && slp_s && !conv_done && !dual_mode_r) |=>
      (sh_r[RES_W-1:1] == $past(sh_r[RES_W-2:0])))
    else $error("one-lane shift wrong");

  lane_off_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (slp_s && !dual_s) |=> !second_lane_oe)
    else $error("second lane driven in one-lane mode");

  echo_follow_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (slp_s && $changed(clk_s)) |=> (echoed_clock_out == $past(clk_s)))
    else $error("echo clock does not follow");

  sar_result_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (conv_done && slp_s && !pat_s) |=> (sh_r == held_r && last_r == held_r))
    else $error("conversion result wrong");

  ready_time_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    // Conversion ends one cycle after the detected edge; then the word is loaded or sleep won
    (state_r == SAR_ACQ && cnv_rise && slp_s) |=>
      conv_done ##1 (left_r != 5'h00 || state_r == SAR_SLEEP))
    else $error("conversion timing wrong");

  load_width_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (conv_done && slp_s) |=> (left_r == (dual_mode_r ? `SAR_BITS_TWO : `SAR_BITS_ONE)))
    else $error("readout length wrong");

endmodule : sar_adc_lvds_readout
`default_nettype wire

// ==== logic/sar_adc_regs.svh ====
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// Register byte offsets
`define SAR_OFS_CTRL     12'h000
`define SAR_OFS_STATUS   12'h004
`define SAR_OFS_RESULT   12'h008
`define SAR_OFS_COUNT    12'h00C

// Result geometry
`define SAR_RES_W        18
`define SAR_BITS_ONE     5'h12
`define SAR_BITS_TWO     5'h09

// Reset values
`define SAR_PAT_RST      18'h0F0F0

// STATUS field positions
`define SAR_ST_STATE_LO  0
`define SAR_ST_AWAKE     2
`define SAR_ST_DUAL      3
`define SAR_ST_PATTERN   4
`define SAR_ST_BUSY      5

// Timing
`define SAR_CLK_NS       20
`define SAR_TCONV_MIN_NS 54
`define SAR_TCONV_MAX_NS 63
`define SAR_SYNC_LAT     2
`define SAR_CONV_CYC     ((`SAR_TCONV_MIN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CONV_WAIT    (`SAR_CONV_CYC - `SAR_SYNC_LAT)

`endif

// ==== logic/sar_adc_pkg.sv ====
`default_nettype none
package sar_adc_pkg;
  typedef enum logic [1:0]
  {
    SAR_SLEEP = 2'b00,
    SAR_ACQ   = 2'b01,
    SAR_CONV  = 2'b10
  } sar_state_t;
endpackage : sar_adc_pkg
`default_nettype wire

// ==== logic/sar_sync.sv ====
`default_nettype none
module sar_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // System clock
  input  wire logic         presetn, // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous input
  output logic      [W-1:0] q        // Synchronised output
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sar_sync
`default_nettype wire

// ==== tb/sar_ctl_model.sv ====
`default_nettype none
module sar_ctl_model (
  input  wire logic pclk, // System clock
  output logic      cs,   // Convert strobe
  output logic      rc,   // Readout clock, idle low between frames
  input  wire logic la,   // First lane
  input  wire logic lb,   // Second lane
  input  wire logic eco   // Echoed clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] cap;
  logic        eco_q;
  logic        dl;
  int          edges;
  initial
  begin
    cs    = 1'b0;
    rc    = 1'b0;
    eco_q = 1'b0;
  end
  // Lanes are latched on the rising echo, lane A first in each pair
  always @(posedge pclk)
  begin
    eco_q <= eco;
    if (eco && !eco_q)
    begin
      edges <= edges + 1;
      cap   <= dl ? {cap[15:0], la, lb} : {cap[16:0], la};
    end
  end
  task automatic frame(input logic d, output logic [17:0] w, output int n);
    dl    = d;
    edges = 0;
    @(posedge pclk) cs <= 1'b1;
    @(posedge pclk) cs <= 1'b0;
    // Extra margin: the design samples pins, so its ready time is late
    repeat (4) @(posedge pclk);
    repeat (d ? 9 : 18)
    begin
      @(posedge pclk) rc <= 1'b1;
      repeat (4) @(posedge pclk);
      rc <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    // Readout is over well before any next strobe
    repeat (6) @(posedge pclk);
    w = cap;
    n = edges;
  endtask : frame
endmodule : sar_ctl_model
`default_nettype wire

// ==== tb/tb_sar_adc_lvds_readout.sv ====
`default_nettype none
`include "sar_adc_regs.svh"
module tb_sar_adc_lvds_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, cs, rc, sleep_n, pat, dual;
  logic [17:0] smp;
  logic        la, la_oe, lb, lb_oe, eco, eco_oe;
  int          num_errors, n_compared, cycles;

  sar_adc_lvds_readout uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convert_strobe(cs), .readout_clock(rc), .sleep_request_n(sleep_n),
    .pattern_force(pat), .dual_lane_select(dual), .analog_sample(smp),
    .first_lane_out(la), .first_lane_oe(la_oe), .second_lane_out(lb),
    .second_lane_oe(lb_oe), .echoed_clock_out(eco), .echoed_clock_oe(eco_oe));
  sar_ctl_model ctl (.pclk(pclk), .cs(cs), .rc(rc), .la(la), .lb(lb), .eco(eco));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check(32'(err), 32'(ee));
  endtask : rdc

  // One conversion; the input moves during readout to prove it was held
  task automatic run(input logic d, input logic [17:0] v, input logic [17:0] e, input int en);
    logic [17:0] w;
    int          n;
    smp  <= v;
    dual <= d;
    repeat (4) @(posedge pclk);
    fork
      ctl.frame(d, w, n);
      begin
        repeat (8) @(posedge pclk);
        smp <= ~v;
      end
    join
    if (en != 0)
    begin
      check(32'(w), 32'(e));
      check(32'(18'(w ^ 18'h20000)), 32'(18'(e + 18'h20000)));
    end
    check(32'(n), 32'(en));
    check(32'(lb_oe), 32'(d && en != 0));
    check(32'({la_oe, eco_oe}), (en != 0) ? 32'h3 : 32'h0);
    if (!d)
      check(32'(lb), 32'h0);
  endtask : run

  task automatic t_regs;
    rdc(`SAR_OFS_CTRL, 32'h0F0F0, 1'b0);
    rdc(`SAR_OFS_STATUS, 32'h05, 1'b0);
    rdc(`SAR_OFS_COUNT, 32'h0, 1'b0);
    rdc(12'h010, 32'h0, 1'b1);
    apb(1'b1, `SAR_OFS_STATUS, 32'hFF);
    rdc(`SAR_OFS_STATUS, 32'h05, 1'b0);
    apb(1'b1, `SAR_OFS_CTRL, 32'hFFFEA5C3);
    rdc(`SAR_OFS_CTRL, 32'h2A5C3, 1'b0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_conv;
    logic [17:0] tab [4] = '{18'h1FFFF, 18'h20000, 18'h00001, 18'h2A5A5};
    for (int i = 0; i < 8; i++)
      run(i[0], tab[i/2], tab[i/2], i[0] ? 9 : 18);
    rdc(`SAR_OFS_RESULT, 32'h2A5A5, 1'b0);
    rdc(`SAR_OFS_COUNT, 32'h8, 1'b0);
    $display("test conversion done");
  endtask : t_conv

  task automatic t_pat;
    pat <= 1'b1;
    run(1'b0, 18'h00001, 18'h2A5C3, 18);
    run(1'b1, 18'h00001, 18'h2A5C3, 9);
    pat <= 1'b0;
    $display("test pattern done");
  endtask : t_pat

  task automatic t_sleep;
    sleep_n <= 1'b0;
    repeat (6) @(posedge pclk);
    check(32'({la_oe, lb_oe, eco_oe, eco}), 32'h0);
    run(1'b1, 18'h12345, 18'h0, 0);
    sleep_n <= 1'b1;
    repeat (6) @(posedge pclk);
    run(1'b1, 18'h12345, 18'h12345, 9);
    $display("test sleep done");
  endtask : t_sleep

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    sleep_n = 1'b1;
    pat     = 1'b0;
    dual    = 1'b0;
    smp     = 18'h00000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_conv();
    t_pat();
    t_sleep();
    summarize();
  end
endmodule : tb_sar_adc_lvds_readout
`default_nettype wire
